// File: dv/potmem_slave_asserts.sv
// Port checks for the dual-pot memory slave
`timescale 1ns/1ps
`default_nettype none
module potmem_slave_asserts #(
	parameter int unsigned WRITE_CYCLES = 20
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe,
	input wire logic i_addr_select_bit0,
	input wire logic i_addr_select_bit1,
	input wire logic i_addr_select_bit2,
	input wire logic [6:0] o_wiper0,
	input wire logic [7:0] o_wiper1,
	input wire logic o_lock_mode,
	input wire logic o_busy,
	input wire logic o_standby
);
	localparam int BUSY_MAX = WRITE_CYCLES + 4;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_nrst);
	// Pin is seen two flops late, so look back two samples
	drive_low_a: assert property (
		$changed(o_sda_oe) |-> !$past(i_scl, 2))
		else $error("sda drive changed with clock high");
	ack_hold_a: assert property (
		$rose(o_sda_oe) |-> o_sda_oe [*6])
		else $error("sda pull too short");
	poll_nack_a: assert property (
		o_busy |-> !$rose(o_sda_oe))
		else $error("answered while busy");
	busy_end_a: assert property (
		$rose(o_busy) |-> ##[1:BUSY_MAX] !o_busy)
		else $error("write never ended");
	busy_min_a: assert property (
		$rose(o_busy) |-> o_busy [*8])
		else $error("write too short");
	standby_a: assert property (
		$fell(o_busy) |-> ##[0:3] o_standby)
		else $error("no standby after write");
	not_both_a: assert property (
		o_standby |-> !o_busy && !o_sda_oe)
		else $error("standby while busy or driving");
	lock_when_a: assert property (
		$changed(o_lock_mode) |-> $fell(o_busy))
		else $error("lock moved outside write end");
	wiper_when_a: assert property (
		$changed(o_wiper1) || $changed(o_wiper0) |-> o_busy)
		else $error("wiper moved outside write");
	clamp_a: assert property (o_wiper0 <= 7'h63)
		else $error("wiper0 above top");
	cover property ($rose(o_lock_mode));
	cover property ($fell(o_lock_mode));
	cover property ($rose(o_busy));
endmodule
bind potmem_slave potmem_slave_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
	.i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(i_scl), .i_sda(i_sda),
	.o_sda(o_sda), .o_sda_oe(o_sda_oe),
	.i_addr_select_bit0(i_addr_select_bit0),
	.i_addr_select_bit1(i_addr_select_bit1),
	.i_addr_select_bit2(i_addr_select_bit2),
	.o_wiper0(o_wiper0), .o_wiper1(o_wiper1), .o_lock_mode(o_lock_mode),
	.o_busy(o_busy), .o_standby(o_standby));
`default_nettype wire

// File: dv/potmem_slave_tb.sv
// Self-checking bench for the dual-pot memory slave
`timescale 1ns/1ps
`default_nettype none
module potmem_slave_tb;
	import potmem_pkg::*;
	typedef struct {
		logic [7:0] a;
		logic [7:0] d;
	} row_s;
	logic i_mclk = 1'b0;
	logic i_nrst = 1'b0;
	logic [2:0] sel = 3'b101;
	wire logic scl;
	wire logic sda_low;
	wire logic sda;
	logic oe, lock, busy, stby, ack;
	logic sdo;
	logic [6:0] w0;
	logic [6:0] ew0 = 7'h00;
	logic [7:0] w1, q;
	logic [7:0] ew1 = 8'h00;
	int err_count = 0;
	int checks_done = 0;
	row_s rows[6] = '{'{8'h00, 8'h55}, '{8'h80, 8'hC3}, '{8'hF8, 8'hAA},
		'{8'hF9, 8'hB2}, '{8'hF9, 8'h64}, '{8'hF9, 8'h63}};
	// Open-drain line with pull-up; the drive value must be low to pull
	assign sda = !(sda_low || (oe && !sdo));
	always #25 i_mclk = ~i_mclk;
	// Write time long enough for an address poll to land inside it
	potmem_slave #(.WRITE_CYCLES(150)) u_dut (
		.i_mclk(i_mclk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda),
		.o_sda(sdo), .o_sda_oe(oe), .i_addr_select_bit0(sel[0]),
		.i_addr_select_bit1(sel[1]), .i_addr_select_bit2(sel[2]),
		.o_wiper0(w0), .o_wiper1(w1), .o_lock_mode(lock),
		.o_busy(busy), .o_standby(stby));
	twi_host_model u_mst (.i_mclk(i_mclk), .i_sda(sda), .o_scl(scl),
		.o_sda_low(sda_low));
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask
	task automatic test_done();
		if (err_count == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic head(input logic [7:0] a);
		u_mst.start();
		u_mst.wbyte({DEV_TYPE_DEF, sel, 1'b0}, ack);
		chk(ack, 1'b1);
		u_mst.wbyte(a, ack);
		chk(ack, 1'b1);
	endtask
	// Lets busy rise before polling it down
	task automatic settle();
		int n;
		n = 0;
		u_mst.tick(8);
		while ((busy !== 1'b0 || stby !== 1'b1) && n < 400) begin
			@(posedge i_mclk);
			n++;
		end
		chk(stby, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		head(a);
		u_mst.wbyte(d, ack);
		chk(ack, 1'b1);
		u_mst.stop();
		settle();
	endtask
	task automatic cur(input logic [7:0] e);
		u_mst.start();
		u_mst.wbyte({DEV_TYPE_DEF, sel, 1'b1}, ack);
		chk(ack, 1'b1);
		u_mst.rbyte(1'b1, q);
		chk(q, e);
		u_mst.stop();
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		head(a);
		cur(e);
	endtask
	initial begin
		repeat (6) @(posedge i_mclk);
		i_nrst <= 1'b1;
		u_mst.tick(3);
		chk({3'h0, sdo, lock, oe, busy, stby}, 8'h01);
		rd(8'h00, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].d);
			if (rows[i].a == ADR_POT1)
				ew1 = rows[i].d;
			if (rows[i].a == ADR_POT0)
				ew0 = (rows[i].d[6:0] > POT0_MAX) ? POT0_MAX : rows[i].d[6:0];
			chk(w1, ew1);
			chk({1'b0, w0}, {1'b0, ew0});
		end
		for (int i = 0; i < 2; i++) begin
			u_mst.start();
			u_mst.wbyte(i ? {DEV_TYPE_DEF, ~sel, 1'b0} :
				{~DEV_TYPE_DEF, sel, 1'b0}, ack);
			chk(ack, 1'b0);
			u_mst.stop();
		end
		// Address poll during the internal write is refused
		head(8'h10);
		u_mst.wbyte(8'h42, ack);
		chk(ack, 1'b1);
		u_mst.stop();
		u_mst.start();
		u_mst.wbyte({DEV_TYPE_DEF, sel, 1'b0}, ack);
		chk(ack, 1'b0);
		chk(busy, 1'b1);
		u_mst.stop();
		settle();
		rd(8'h10, 8'h42);
		// New select pin levels move the device address
		sel <= 3'b010;
		u_mst.tick(4);
		rd(8'h00, 8'h55);
		// Page from FDh wraps through FFh to 00h
		head(8'hFD);
		for (int i = 0; i < 8; i++) begin
			u_mst.wbyte(8'hA0 + 8'(i), ack);
			chk(ack, 1'b1);
		end
		u_mst.stop();
		settle();
		for (int i = 0; i < 8; i++)
			rd(8'hFD + 8'(i), 8'hA0 + 8'(i));
		rd(8'hFF, 8'hA2);
		cur(8'hA3);
		// Sequential read: master acks the first byte, wraps to 00h
		head(8'hFF);
		u_mst.start();
		u_mst.wbyte({DEV_TYPE_DEF, sel, 1'b1}, ack);
		chk(ack, 1'b1);
		u_mst.rbyte(1'b0, q);
		chk(q, 8'hA2);
		u_mst.rbyte(1'b1, q);
		chk(q, 8'hA3);
		u_mst.stop();
		// A second start drops the unfinished page
		head(8'h80);
		u_mst.wbyte(8'h11, ack);
		u_mst.start();
		u_mst.recover();
		u_mst.stop();
		settle();
		rd(8'h80, 8'hC3);
		wr(ADR_CFG, 8'h03);
		wr(ADR_KEY1, KEY_LOCK1);
		wr(ADR_KEY2, KEY_LOCK2);
		chk(lock, 1'b1);
		wr(8'h00, 8'h99);
		rd(8'h00, 8'hA3);
		wr(8'h80, 8'h99);
		rd(8'h80, 8'hC3);
		wr(ADR_CFG, 8'h01);
		wr(8'h80, 8'h5A);
		rd(8'h80, 8'h5A);
		wr(ADR_KEY1, KEY_UNL1);
		chk(lock, 1'b1);
		wr(ADR_KEY2, KEY_UNL2);
		chk(lock, 1'b0);
		wr(ADR_CFG, 8'h04);
		wr(ADR_KEY1, KEY_LOCK1);
		wr(ADR_KEY2, KEY_LOCK2);
		wr(ADR_POT1, 8'h11);
		chk(w1, 8'hAA);
		wr(ADR_CFG, 8'h03);
		rd(ADR_CFG, 8'h04);
		// Reset mid-run clears lock, wiper1 and the array
		i_nrst <= 1'b0;
		u_mst.tick(3);
		i_nrst <= 1'b1;
		u_mst.tick(3);
		chk({3'h0, sdo, lock, oe, busy, stby}, 8'h01);
		chk(w1, 8'h00);
		rd(ADR_CFG, 8'h00);
		test_done();
	end
	initial begin
		repeat (80000) @(posedge i_mclk);
		err_count++;
		test_done();
	end
endmodule
`default_nettype wire

// File: dv/twi_host_model.sv
// Behavioural 2-wire bus master for the slave's pins
`timescale 1ns/1ps
`default_nettype none
module twi_host_model (
	input wire logic i_mclk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	logic r;
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_mclk);
	endtask
	// Data moves only while the clock is low
	task automatic bitc(input logic b, output logic q);
		o_sda_low <= !b;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		q = i_sda;
		o_scl <= 1'b0;
		tick(2);
	endtask
	// Also serves as a repeated start
	task automatic start();
		o_sda_low <= 1'b0;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b1;
		tick(4);
		o_scl <= 1'b0;
		tick(2);
	endtask
	// Clock then stays high: no clock outside frames
	task automatic stop();
		o_sda_low <= 1'b1;
		tick(2);
		o_scl <= 1'b1;
		tick(4);
		o_sda_low <= 1'b0;
		tick(4);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		for (int i = 7; i >= 0; i--)
			bitc(d[i], r);
		bitc(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			bitc(1'b1, r);
			d = {d[6:0], r};
		end
		bitc(last, r);
	endtask
	// Frees a slave stuck mid-byte, then opens a frame
	task automatic recover();
		for (int i = 0; i < 9; i++)
			bitc(1'b1, r);
		start();
	endtask
endmodule
`default_nettype wire

// File: logic/fifo2.sv
// Small valid/ready FIFO holding received write bytes
`timescale 1ns/1ps
`default_nettype none
module fifo2 #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_flush,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} fifo_s;

	fifo_s s_q;
	fifo_s s_d;
	logic push;
	logic pop;

	always_comb begin
		s_d = s_q;
		push = i_in_valid && o_in_ready;
		pop = o_out_valid && i_out_ready;
		if (i_flush) begin
			s_d.wp = '0;
			s_d.rp = '0;
			s_d.cnt = '0;
		end else begin
			if (push) begin
				s_d.mem[s_q.wp] = i_in_data;
				s_d.wp = (s_q.wp == AW'(DEPTH - 1)) ? '0 : s_q.wp + 1'b1;
			end
			if (pop) begin
				s_d.rp = (s_q.rp == AW'(DEPTH - 1)) ? '0 : s_q.rp + 1'b1;
			end
			s_d.cnt = s_q.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
		end
	end

	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_in_ready = (s_q.cnt != (AW + 1)'(DEPTH)) && !i_flush;
	assign o_out_valid = (s_q.cnt != '0);
	assign o_out_data = s_q.mem[s_q.rp];
endmodule
`default_nettype wire

// File: logic/potmem_slave.sv
// 2-wire slave with 256-byte memory, wiper bytes and software lock
//
// Function
// - 256 bytes, 8-bit word address random access
// - Pot0 from F9h, MSB ignored, clamp 63h
// - Pot1 from F8h, full 256 positions
// - Config bit2 plus lock protects F8h-FFh
// - Config bit1 plus lock protects 80h-F7h
// - Config bit0 plus lock protects 00h-7Fh
// - Block bits change only if page unprotected
// - Keys 56h/25h at FBh/FCh enter lock
// - Keys 67h/36h at FBh/FCh leave lock
// - Config changes allowed while page unprotected
// - Respond only when select bits match pins
// - Data changes only with clock low
// - START is falling data, clock high
// - STOP is rising data, clock high
// - Acknowledge low through ninth clock pulse
// - Standby after reset, STOP, internal completion
// - Address word: type, select bits, R/W
// - Page of eight, committed only at STOP
// - Address counter increments and wraps
`timescale 1ns/1ps
`default_nettype none
module potmem_slave
	import potmem_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = T_WRITE_CYC,
	parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEF
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe,
	input wire logic i_addr_select_bit0,
	input wire logic i_addr_select_bit1,
	input wire logic i_addr_select_bit2,
	output logic [6:0] o_wiper0,
	output logic [7:0] o_wiper1,
	output logic o_lock_mode,
	output logic o_busy,
	output logic o_standby
);
	typedef struct packed {
		bus_state_e st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic rw;
		logic sda_oe;
		logic mack;
		logic [7:0] ptr;
		logic [7:0] page_addr;
		logic [3:0] page_n;
		logic [PAGE_BYTES-1:0][7:0] page;
		logic commit_pend;
		logic busy;
		logic [WCNT_W-1:0] wcnt;
		logic key_touch;
		logic lock;
		logic scl_p;
		logic sda_p;
		logic [MEM_DEPTH-1:0][7:0] mem;
		logic [6:0] wiper0;
		logic [7:0] wiper1;
	} core_s;

	core_s s_q;
	core_s s_d;

	logic [4:0] pins_sync;
	logic scl;
	logic sda;
	logic [2:0] asel;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	logic flush;
	logic in_valid;
	logic in_ready;
	logic out_valid;
	logic out_ready;
	logic [7:0] out_data;

	// Pins are asynchronous to i_mclk; SCL is sampled, not used as a clock
	sync2 #(
		.W(5)
	) u_sync (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_async({i_addr_select_bit2, i_addr_select_bit1,
			i_addr_select_bit0, i_sda, i_scl}),
		.o_sync(pins_sync)
	);

	assign scl = pins_sync[0];
	assign sda = pins_sync[1];
	assign asel = pins_sync[4:2];

	assign scl_rise = scl && !s_q.scl_p;
	assign scl_fall = !scl && s_q.scl_p;
	assign start_det = scl && s_q.scl_p && s_q.sda_p && !sda;
	assign stop_det = scl && s_q.scl_p && !s_q.sda_p && sda;
	// FIFO bytes are dropped on any START or STOP; START also drops the page, STOP commits it
	assign flush = start_det || stop_det;

	// Byte received and offered to the FIFO at the ack decision
	assign in_valid = (s_q.st == ST_WDATA) && scl_fall && !flush &&
		(s_q.bitcnt == BYTE_BITS);
	assign out_ready = (s_q.page_n < PAGE_BYTES_N) && !s_q.commit_pend;

	fifo2 #(
		.W(8),
		.DEPTH(2)
	) u_fifo (
		.i_mclk(i_mclk),
		.i_nrst(i_nrst),
		.i_flush(flush),
		.i_in_valid(in_valid),
		.o_in_ready(in_ready),
		.i_in_data(s_q.shreg),
		.o_out_valid(out_valid),
		.i_out_ready(out_ready),
		.o_out_data(out_data)
	);

	function automatic logic is_prot(input logic [7:0] a,
		input logic [7:0] cfg, input logic lock);
		logic hit;
		hit = 1'b0;
		if (a >= ADR_PAGE_LO) begin
			hit = cfg[CFG_PAGE_BIT];
		end else if (a >= ADR_UBLK_LO) begin
			hit = cfg[CFG_UBLK_BIT];
		end else begin
			hit = cfg[CFG_LBLK_BIT];
		end
		// Config byte sits in the page, so its block bits follow bit 2
		return lock && hit;
	endfunction

	always_comb begin
		logic [7:0] a;
		logic [7:0] rd;
		a = '0;
		rd = s_q.mem[s_q.ptr];
		s_d = s_q;
		s_d.scl_p = scl;
		s_d.sda_p = sda;

		// Wiper outputs follow their memory bytes
		s_d.wiper1 = s_q.mem[ADR_POT1];
		if (s_q.mem[ADR_POT0][6:0] > POT0_MAX) begin
			s_d.wiper0 = POT0_MAX;
		end else begin
			s_d.wiper0 = s_q.mem[ADR_POT0][6:0];
		end

		// Drain the FIFO into the page latch
		if (out_valid && out_ready) begin
			s_d.page[s_q.page_n[2:0]] = out_data;
			s_d.page_n = s_q.page_n + 4'h1;
		end

		// Internal write timer; keys are judged once it expires
		if (s_q.busy) begin
			s_d.wcnt = s_q.wcnt - 1'b1;
			if (s_q.wcnt == '0) begin
				s_d.busy = 1'b0;
				s_d.key_touch = 1'b0;
				if (s_q.key_touch) begin
					if (s_q.mem[ADR_KEY1] == KEY_LOCK1 &&
						s_q.mem[ADR_KEY2] == KEY_LOCK2) begin
						s_d.lock = 1'b1;
					end else if (s_q.mem[ADR_KEY1] == KEY_UNL1 &&
						s_q.mem[ADR_KEY2] == KEY_UNL2) begin
						s_d.lock = 1'b0;
					end
				end
			end
		end

		// Commit the latched page in one cycle, then start the write timer
		if (s_q.commit_pend) begin
			for (int i = 0; i < PAGE_BYTES; i++) begin
				if (4'(i) < s_q.page_n) begin
					a = s_q.page_addr + 8'(i);
					if (!is_prot(a, s_q.mem[ADR_CFG], s_q.lock)) begin
						s_d.mem[a] = s_q.page[i];
						if (a == ADR_KEY1 || a == ADR_KEY2) begin
							s_d.key_touch = 1'b1;
						end
					end
				end
			end
			s_d.commit_pend = 1'b0;
			s_d.page_n = '0;
			s_d.busy = 1'b1;
			s_d.wcnt = WCNT_W'(WRITE_CYCLES - 1);
		end

		if (start_det) begin
			s_d.st = ST_ADDR;
			s_d.bitcnt = '0;
			s_d.sda_oe = 1'b0;
			s_d.page_n = '0;
		end else if (stop_det) begin
			s_d.st = ST_IDLE;
			s_d.sda_oe = 1'b0;
			if (s_q.page_n != '0) begin
				s_d.commit_pend = 1'b1;
			end
		end else begin
			unique case (s_q.st)
				ST_IDLE: begin
					s_d.sda_oe = 1'b0;
				end
				ST_ADDR, ST_WORD, ST_WDATA: begin
					if (scl_rise && s_q.bitcnt < BYTE_BITS) begin
						s_d.shreg = {s_q.shreg[6:0], sda};
						s_d.bitcnt = s_q.bitcnt + 4'h1;
					end
					if (scl_fall && s_q.bitcnt == BYTE_BITS) begin
						s_d.bitcnt = '0;
						if (s_q.st == ST_ADDR) begin
							// Busy writing: refuse, the master polls again
							if (s_q.shreg[DA_TYPE_HI:DA_TYPE_LO] == DEV_TYPE &&
								s_q.shreg[DA_SEL_HI:DA_SEL_LO] == asel &&
								!s_q.busy && !s_q.commit_pend) begin
								s_d.sda_oe = 1'b1;
								s_d.rw = s_q.shreg[DA_RW];
								s_d.st = ST_ADDR_ACK;
							end else begin
								s_d.st = ST_IDLE;
							end
						end else if (s_q.st == ST_WORD) begin
							s_d.sda_oe = 1'b1;
							s_d.ptr = s_q.shreg;
							s_d.page_addr = s_q.shreg;
							s_d.page_n = '0;
							s_d.st = ST_WORD_ACK;
						end else begin
							// Full FIFO gives no acknowledge, byte is lost
							s_d.sda_oe = in_ready;
							if (in_ready) begin
								s_d.ptr = s_q.ptr + 8'h01;
							end
							s_d.st = ST_WDATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (scl_fall) begin
						if (s_q.rw) begin
							s_d.tx = rd;
							s_d.ptr = s_q.ptr + 8'h01;
							s_d.sda_oe = !rd[7];
							s_d.bitcnt = '0;
							s_d.st = ST_RDATA;
						end else begin
							s_d.sda_oe = 1'b0;
							s_d.st = ST_WORD;
						end
					end
				end
				ST_WORD_ACK, ST_WDATA_ACK: begin
					if (scl_fall) begin
						s_d.sda_oe = 1'b0;
						s_d.st = ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_rise) begin
						s_d.bitcnt = s_q.bitcnt + 4'h1;
					end
					// Data moves only after SCL has fallen
					if (scl_fall) begin
						if (s_q.bitcnt == BYTE_BITS) begin
							s_d.sda_oe = 1'b0;
							s_d.bitcnt = '0;
							s_d.mack = 1'b0;
							s_d.st = ST_RACK;
						end else begin
							s_d.tx = {s_q.tx[6:0], 1'b0};
							s_d.sda_oe = !s_q.tx[6];
						end
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						s_d.mack = !sda;
					end
					if (scl_fall) begin
						if (s_q.mack) begin
							s_d.tx = rd;
							s_d.ptr = s_q.ptr + 8'h01;
							s_d.sda_oe = !rd[7];
							s_d.st = ST_RDATA;
						end else begin
							s_d.st = ST_IDLE;
						end
					end
				end
				default: begin
					s_d.st = ST_IDLE;
					s_d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// Memory resets to zero: contents model an erased array, lock off
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= '0;
			s_q.scl_p <= 1'b1;
			s_q.sda_p <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_sda = 1'b0;
	assign o_sda_oe = s_q.sda_oe;
	assign o_wiper0 = s_q.wiper0;
	assign o_wiper1 = s_q.wiper1;
	assign o_lock_mode = s_q.lock;
	assign o_busy = s_q.busy || s_q.commit_pend;
	assign o_standby = (s_q.st == ST_IDLE) && !s_q.busy &&
		!s_q.commit_pend;
endmodule
`default_nettype wire

// File: logic/sync2.sv
// Two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
	parameter int W = 1
) (
	input wire logic i_mclk,
	input wire logic i_nrst,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	always_comb begin
		s_d.s1 = i_async;
		s_d.s2 = s_q.s1;
	end

	// Idle bus lines are high, so reset to ones
	always_ff @(posedge i_mclk or negedge i_nrst) begin
		if (!i_nrst) begin
			s_q <= '1;
		end else begin
			s_q <= s_d;
		end
	end

	assign o_sync = s_q.s2;
endmodule
`default_nettype wire

// File: pkg/potmem_pkg.sv
// Shared constants and types for the dual-pot secure memory slave
package potmem_pkg;
	localparam int MEM_DEPTH = 256;
	localparam int PAGE_BYTES = 8;
	localparam logic [3:0] PAGE_BYTES_N = 4'h8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam int WCNT_W = 20;

	// Memory map
	localparam logic [7:0] ADR_POT1 = 8'hF8;
	localparam logic [7:0] ADR_POT0 = 8'hF9;
	localparam logic [7:0] ADR_CFG = 8'hFA;
	localparam logic [7:0] ADR_KEY1 = 8'hFB;
	localparam logic [7:0] ADR_KEY2 = 8'hFC;
	localparam logic [7:0] ADR_PAGE_LO = 8'hF8;
	localparam logic [7:0] ADR_UBLK_LO = 8'h80;

	// Protection configuration fields
	localparam int CFG_PAGE_BIT = 2;
	localparam int CFG_UBLK_BIT = 1;
	localparam int CFG_LBLK_BIT = 0;

	// Key pairs
	localparam logic [7:0] KEY_LOCK1 = 8'h56;
	localparam logic [7:0] KEY_LOCK2 = 8'h25;
	localparam logic [7:0] KEY_UNL1 = 8'h67;
	localparam logic [7:0] KEY_UNL2 = 8'h36;

	localparam logic [6:0] POT0_MAX = 7'h63;

	// Bus address word layout
	localparam int DA_TYPE_HI = 7;
	localparam int DA_TYPE_LO = 4;
	localparam int DA_SEL_HI = 3;
	localparam int DA_SEL_LO = 1;
	localparam int DA_RW = 0;
	// Arbitrary type code, not taken from any real part
	localparam logic [3:0] DEV_TYPE_DEF = 4'h5;

	// Internal write time
	localparam int MCLK_PERIOD_NS = 50;
	localparam int T_WRITE_NS = 10_000_000;
	localparam int T_WRITE_CYC =
		(T_WRITE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_ADDR = 4'h1,
		ST_ADDR_ACK = 4'h2,
		ST_WORD = 4'h3,
		ST_WORD_ACK = 4'h4,
		ST_WDATA = 4'h5,
		ST_WDATA_ACK = 4'h6,
		ST_RDATA = 4'h7,
		ST_RACK = 4'h8
	} bus_state_e;
endpackage
